// file: charger_input_supervisor.sv
// Charger input supervisor: input qualification, current selection, events and registers
`timescale 1ns/1ns
module charger_input_supervisor #(
	parameter logic [11:0] PROG_MA_DEFAULT = 12'd1000
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [13:0] charger_supply_input,
	input wire logic [13:0] wall_supply_select_input,
	input wire logic [13:0] system_supply_rail,
	input wire logic [13:0] system_rail_target,
	input wire logic charge_level_select_input,
	input wire logic [11:0] charge_current_resistor_pin,
	input wire logic sys_overload,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic charge_enable,
	output logic under_voltage,
	output logic dynamic_charge_throttle,
	output logic sys_from_input,
	output logic sys_from_battery,
	output cis_pkg::cis_curr_t curr_sel,
	output logic interrupt_request_n
);
	logic [7:0] ctrl_r;
	logic input_event_flag_r;
	logic input_event_flag_nxt;
	logic [7:0] rdata_r;
	logic uv_r;
	cis_pkg::cis_state_t state_r;
	cis_pkg::cis_state_t state_nxt;
	cis_pkg::cis_curr_t curr_w;
	logic valid_sync;
	logic rise;
	logic fall;

	wire [1:0] overvoltage_threshold_select = ctrl_r[cis_pkg::CIS_CTRL_OVP_LSB +: 2];
	wire flag_en = ctrl_r[cis_pkg::CIS_CTRL_FLAG_EN];
	wire connect_event_enable = ctrl_r[cis_pkg::CIS_CTRL_CON_EN];
	wire disconnect_event_enable = ctrl_r[cis_pkg::CIS_CTRL_DIS_EN];

	// Threshold decode
	logic [13:0] ovp_mv;
	always_comb begin
		case (overvoltage_threshold_select)
			2'b00: ovp_mv = cis_pkg::CIS_OVP_MV_0;
			2'b01: ovp_mv = cis_pkg::CIS_OVP_MV_1;
			2'b10: ovp_mv = cis_pkg::CIS_OVP_MV_2;
			default: ovp_mv = cis_pkg::CIS_OVP_MV_3;
		endcase
	end

	wire over_v = charger_supply_input > ovp_mv;
	wire below_resume = charger_supply_input < cis_pkg::CIS_OVP_RESUME_MV;
	wire below_uv = charger_supply_input < cis_pkg::CIS_UVLO_MV;
	wire above_restart = charger_supply_input >=
		14'(cis_pkg::CIS_UVLO_MV + cis_pkg::CIS_UVLO_HYST_MV);
	wire wall_mode = wall_supply_select_input > cis_pkg::CIS_WALL_THR_MV;
	wire in_window = !below_uv && !over_v;
	wire [13:0] sag_floor = (system_rail_target > cis_pkg::CIS_SAG_MV) ?
		14'(system_rail_target - cis_pkg::CIS_SAG_MV) : 14'h0000;

	// Under-voltage flag with hysteresis
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			uv_r <= 1'b1;
		end else if (below_uv) begin
			uv_r <= 1'b1;
		end else if (above_restart) begin
			uv_r <= 1'b0;
		end
	end

	// Qualification state: OVP latches until input drops below resume level
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			cis_pkg::CIS_ST_OFF: begin
				if (over_v) begin
					state_nxt = cis_pkg::CIS_ST_OVP;
				end else if (!uv_r && !below_uv) begin
					state_nxt = cis_pkg::CIS_ST_OK;
				end
			end
			cis_pkg::CIS_ST_OK: begin
				if (over_v) begin
					state_nxt = cis_pkg::CIS_ST_OVP;
				end else if (below_uv) begin
					state_nxt = cis_pkg::CIS_ST_OFF;
				end
			end
			cis_pkg::CIS_ST_OVP: begin
				if (below_resume && !over_v) begin
					state_nxt = cis_pkg::CIS_ST_OFF;
				end
			end
			default: state_nxt = cis_pkg::CIS_ST_OFF;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_r <= cis_pkg::CIS_ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	wire charge_ok = (state_r == cis_pkg::CIS_ST_OK) && !over_v && !below_uv;

	cis_edge_det u_edge (
		.sys_clk(sys_clk),
		.reset(reset),
		.level_in(in_window),
		.level_sync(valid_sync),
		.rise(rise),
		.fall(fall)
	);

	wire [11:0] prog_ma = (charge_current_resistor_pin == 12'h000) ?
		PROG_MA_DEFAULT : charge_current_resistor_pin;

	cis_curr_sel u_curr (
		.wall_mode(wall_mode),
		.charge_level_select_input(charge_level_select_input),
		.prog_ma(prog_ma),
		.curr(curr_w)
	);

	// Event flag: hardware set wins over read clear
	wire ev_con = rise && connect_event_enable && flag_en;
	wire ev_dis = fall && disconnect_event_enable && flag_en;
	wire flag_read = reg_rd && (reg_addr == cis_pkg::CIS_ADDR_STAT);
	always_comb begin
		input_event_flag_nxt = input_event_flag_r;
		if (flag_read) begin
			input_event_flag_nxt = 1'b0;
		end
		if (ev_con || ev_dis) begin
			input_event_flag_nxt = 1'b1;
		end
	end

	// Register write
	wire ctrl_wr = reg_wr && (reg_addr == cis_pkg::CIS_ADDR_CTRL);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ctrl_r <= cis_pkg::CIS_CTRL_RESET;
			input_event_flag_r <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				ctrl_r <= {3'b000, reg_wdata[4:0]};
			end
			input_event_flag_r <= input_event_flag_nxt;
		end
	end

	// Read mux; status shows flag before the read clears it
	logic [7:0] rd_mux;
	always_comb begin
		case (reg_addr)
			cis_pkg::CIS_ADDR_CTRL: rd_mux = ctrl_r;
			cis_pkg::CIS_ADDR_STAT: rd_mux = {3'b000, uv_r, state_r == cis_pkg::CIS_ST_OVP,
				wall_mode, valid_sync, input_event_flag_r};
			cis_pkg::CIS_ADDR_CURR: rd_mux = curr_w.ichg_ma[11:4];
			cis_pkg::CIS_ADDR_ILIM: rd_mux = curr_w.ilim_ma[11:4];
			default: rd_mux = 8'h00;
		endcase
	end

	// Outputs registered to keep data ports glitch free
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rdata_r <= 8'h00;
			charge_enable <= 1'b0;
			under_voltage <= 1'b1;
			dynamic_charge_throttle <= 1'b0;
			sys_from_input <= 1'b0;
			sys_from_battery <= 1'b1;
			curr_sel <= '0;
		end else begin
			rdata_r <= reg_rd ? rd_mux : 8'h00;
			charge_enable <= charge_ok;
			under_voltage <= uv_r;
			dynamic_charge_throttle <= charge_ok && (system_supply_rail < sag_floor);
			sys_from_input <= charge_ok;
			sys_from_battery <= !charge_ok || sys_overload;
			curr_sel <= curr_w;
		end
	end

	assign reg_rdata = rdata_r;
	assign interrupt_request_n = !input_event_flag_r;

	AST_OVP_BLOCKS: assert property (@(posedge sys_clk) disable iff (reset)
		over_v |=> !charge_enable) else $error("charge on during over-voltage");
	AST_OVP_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
		(state_r == cis_pkg::CIS_ST_OVP) && !below_resume |=> state_r == cis_pkg::CIS_ST_OVP)
		else $error("over-voltage released early");
	AST_UV_BLOCKS: assert property (@(posedge sys_clk) disable iff (reset)
		below_uv |=> uv_r && !charge_enable) else $error("charge on in under-voltage");
	AST_WALL_LIMIT: assert property (@(posedge sys_clk) disable iff (reset)
		wall_mode |=> curr_sel.ilim_ma == cis_pkg::CIS_ILIM_WALL)
		else $error("wall limit wrong");
	AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (reset)
		ev_con || ev_dis |=> input_event_flag_r && !interrupt_request_n)
		else $error("event not flagged");
	AST_FLAG_CLEAR: assert property (@(posedge sys_clk) disable iff (reset)
		flag_read && !ev_con && !ev_dis |=> !input_event_flag_r)
		else $error("flag not cleared by read");
	AST_READ_DATA: assert property (@(posedge sys_clk) disable iff (reset)
		flag_read |=> reg_rdata[0] == $past(input_event_flag_r))
		else $error("flag read value wrong");
	AST_NO_SPUR: assert property (@(posedge sys_clk) disable iff (reset)
		!input_event_flag_r && !ev_con && !ev_dis |=> !input_event_flag_r)
		else $error("flag set without event");
	AST_THROTTLE: assert property (@(posedge sys_clk) disable iff (reset)
		!charge_ok |=> !dynamic_charge_throttle) else $error("throttle without charge");

	// Further behaviours; the OVP latch, OVP resume and input-valid delay checks use named sequences
	sequence seq_ovp_seen;
		##1 state_r == cis_pkg::CIS_ST_OVP;
	endsequence
	sequence seq_ovp_released;
		##1 state_r == cis_pkg::CIS_ST_OFF;
	endsequence
	sequence seq_valid_high;
		##2 valid_sync;
	endsequence
	sequence seq_valid_low;
		##2 !valid_sync;
	endsequence

	AST_OVP_LATCH: assert property (@(posedge sys_clk) disable iff (reset)
		over_v |-> seq_ovp_seen) else $error("over-voltage not latched");
	AST_OVP_RESUME: assert property (@(posedge sys_clk) disable iff (reset)
		(state_r == cis_pkg::CIS_ST_OVP) && below_resume |-> seq_ovp_released)
		else $error("over-voltage latch stuck");
	AST_UV_RESTART: assert property (@(posedge sys_clk) disable iff (reset)
		uv_r && above_restart |=> !uv_r) else $error("under-voltage not released");
	AST_VALID_RISE: assert property (@(posedge sys_clk) disable iff (reset)
		in_window |-> seq_valid_high) else $error("input valid not reported");
	AST_VALID_FALL: assert property (@(posedge sys_clk) disable iff (reset)
		!in_window |-> seq_valid_low) else $error("input valid reported late");
	AST_EDGE_ONCE: assert property (@(posedge sys_clk) disable iff (reset)
		rise || fall |=> !rise && !fall) else $error("edge pulse too long");
	AST_IRQ_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
		!interrupt_request_n && !flag_read |=> !interrupt_request_n)
		else $error("interrupt dropped before read");
	AST_WALL_STATUS: assert property (@(posedge sys_clk) disable iff (reset)
		flag_read |=> reg_rdata[2] == $past(wall_mode)) else $error("wall status wrong");
	AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (reset)
		!reg_rd |=> reg_rdata == 8'h00) else $error("read data without strobe");
	AST_SRC_INPUT: assert property (@(posedge sys_clk) disable iff (reset)
		charge_ok |=> sys_from_input) else $error("input path off with valid input");
	AST_SRC_BATT: assert property (@(posedge sys_clk) disable iff (reset)
		!charge_ok |=> sys_from_battery && !sys_from_input)
		else $error("battery path off without input");
endmodule

// file: charger_input_supervisor_bench.sv
// Self-checking bench for the charger input supervisor
`timescale 1ns/1ns
module charger_input_supervisor_bench;
	logic sys_clk, reset, lvl, ovl, reg_wr, reg_rd;
	logic charge_enable, under_voltage, thr, sfi, sfb, irq_n;
	logic [13:0] vin, wall, rail, target;
	logic [11:0] prog, e;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	cis_pkg::cis_curr_t curr;
	int failures, cmp_count;
	logic [13:0] ovt [4];
	charger_input_supervisor u_charger_input_supervisor (.sys_clk(sys_clk), .reset(reset),
		.charger_supply_input(vin), .wall_supply_select_input(wall),
		.system_supply_rail(rail), .system_rail_target(target),
		.charge_level_select_input(lvl), .charge_current_resistor_pin(prog),
		.sys_overload(ovl), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .charge_enable(charge_enable),
		.under_voltage(under_voltage), .dynamic_charge_throttle(thr),
		.sys_from_input(sfi), .sys_from_battery(sfb), .curr_sel(curr),
		.interrupt_request_n(irq_n));
	cis_host_model u_cis_host_model (.sys_clk(sys_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("Compares %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Outputs and events lag by up to three cycles, so six is ample
	task automatic settle();
		repeat (6) @(posedge sys_clk);
		#1;
	endtask
	initial begin
		#(100 * 5000);
		failures++;
		print_verdict();
	end
	initial begin
		reset = 1'b1;
		vin = 14'h0000;
		wall = 14'h0000;
		rail = 14'he10;
		target = 14'he10;
		lvl = 1'b0;
		ovl = 1'b0;
		prog = 12'h3e8;
		failures = 0;
		cmp_count = 0;
		ovt[0] = cis_pkg::CIS_OVP_MV_0;
		ovt[1] = cis_pkg::CIS_OVP_MV_1;
		ovt[2] = cis_pkg::CIS_OVP_MV_2;
		ovt[3] = cis_pkg::CIS_OVP_MV_3;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(charge_enable, 12'h000);
		chk(under_voltage, 12'h001);
		chk(irq_n, 12'h001);
		u_cis_host_model.rd(cis_pkg::CIS_ADDR_CTRL, d);
		chk(d, 12'h000);
		u_cis_host_model.wr(cis_pkg::CIS_ADDR_CTRL, 8'hff);
		u_cis_host_model.rd(cis_pkg::CIS_ADDR_CTRL, d);
		chk(d, 12'h01f);
		u_cis_host_model.wr(cis_pkg::CIS_ADDR_CTRL, 8'h1c);
		u_cis_host_model.rd(4'h9, d);
		chk(d, 12'h000);
		@(posedge sys_clk);
		vin <= 14'h1388;
		settle();
		chk(charge_enable, 12'h001);
		chk(under_voltage, 12'h000);
		chk(irq_n, 12'h000);
		chk(sfi, 12'h001);
		chk(sfb, 12'h000);
		u_cis_host_model.rd(cis_pkg::CIS_ADDR_STAT, d);
		chk(d, 12'h003);
		u_cis_host_model.rd(cis_pkg::CIS_ADDR_STAT, d);
		chk(d, 12'h002);
		chk(irq_n, 12'h001);
		@(posedge sys_clk);
		ovl <= 1'b1;
		settle();
		chk({sfi, sfb}, 12'h003);
		ovl <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			wall <= i[1] ? 14'h7d0 : 14'h000;
			lvl <= i[0];
			settle();
			e = i[1] ? cis_pkg::CIS_ILIM_WALL :
				(i[0] ? cis_pkg::CIS_ILIM_USB_HI : cis_pkg::CIS_ILIM_USB_LO);
			chk(curr.ilim_ma, e);
			u_cis_host_model.rd(cis_pkg::CIS_ADDR_ILIM, d);
			chk(d, e[11:4]);
			e = i[1] ? (i[0] ? prog : 12'(prog / cis_pkg::CIS_WALL_DIV)) :
				(i[0] ? cis_pkg::CIS_ICHG_USB_HI : cis_pkg::CIS_ICHG_USB_LO);
			chk(curr.ichg_ma, e);
			u_cis_host_model.rd(cis_pkg::CIS_ADDR_CURR, d);
			chk(d, e[11:4]);
			chk(curr.ipre_ma, i[1] ? prog / cis_pkg::CIS_PRE_DIV : cis_pkg::CIS_IPRE_USB);
			u_cis_host_model.rd(cis_pkg::CIS_ADDR_STAT, d);
			chk(d[2], i[1]);
		end
		@(posedge sys_clk);
		wall <= 14'h000;
		rail <= 14'hd16;
		settle();
		chk(thr, 12'h001);
		rail <= 14'hd7a;
		settle();
		chk(thr, 12'h000);
		for (int i = 0; i < 4; i++) begin
			u_cis_host_model.wr(cis_pkg::CIS_ADDR_CTRL, 8'h1c | i[7:0]);
			vin <= ovt[i] - 14'h032;
			settle();
			chk(charge_enable, 12'h001);
			vin <= ovt[i] + 14'h032;
			settle();
			chk(charge_enable, 12'h000);
			u_cis_host_model.rd(cis_pkg::CIS_ADDR_STAT, d);
			chk(d[3:1], 12'h004);
			vin <= 14'h1964;
			settle();
			chk(charge_enable, 12'h000);
			vin <= 14'h170c;
			settle();
			chk(charge_enable, 12'h001);
		end
		u_cis_host_model.wr(cis_pkg::CIS_ADDR_CTRL, 8'h0c);
		u_cis_host_model.rd(cis_pkg::CIS_ADDR_STAT, d);
		vin <= 14'hd48;
		settle();
		chk({charge_enable, under_voltage}, 12'h001);
		chk(irq_n, 12'h001);
		chk(sfb, 12'h001);
		vin <= 14'hed8;
		settle();
		chk(charge_enable, 12'h000);
		vin <= 14'hfa0;
		settle();
		chk(charge_enable, 12'h001);
		chk(irq_n, 12'h000);
		u_cis_host_model.rd(cis_pkg::CIS_ADDR_STAT, d);
		chk(d[0], 12'h001);
		print_verdict();
	end
endmodule

// file: cis_curr_sel.sv
// Current limit and charge current selection from mode pins
`timescale 1ns/1ns
module cis_curr_sel (
	input wire logic wall_mode,
	input wire logic charge_level_select_input,
	input wire logic [11:0] prog_ma,
	output cis_pkg::cis_curr_t curr
);
	wire [11:0] wall_ichg = charge_level_select_input ? prog_ma : 12'(prog_ma / cis_pkg::CIS_WALL_DIV);
	wire [11:0] usb_ilim = charge_level_select_input ? cis_pkg::CIS_ILIM_USB_HI : cis_pkg::CIS_ILIM_USB_LO;
	wire [11:0] usb_ichg = charge_level_select_input ? cis_pkg::CIS_ICHG_USB_HI : cis_pkg::CIS_ICHG_USB_LO;
	assign curr.ilim_ma = wall_mode ? cis_pkg::CIS_ILIM_WALL : usb_ilim;
	assign curr.ichg_ma = wall_mode ? wall_ichg : usb_ichg;
	// In wall mode precondition is a tenth of the programmed current, not of the divided one
	assign curr.ipre_ma = wall_mode ? 12'(prog_ma / cis_pkg::CIS_PRE_DIV) : cis_pkg::CIS_IPRE_USB;
endmodule

// file: cis_edge_det.sv
// Synchronizer and edge detector for input-valid
`timescale 1ns/1ns
module cis_edge_det (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic level_in,
	output logic level_sync,
	output logic rise,
	output logic fall
);
	logic meta_r;
	logic sync_r;
	logic prev_r;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= level_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end
	assign level_sync = sync_r;
	assign rise = sync_r & ~prev_r;
	assign fall = ~sync_r & prev_r;
endmodule

// file: cis_host_model.sv
// Host side model: register access over the plain strobe port
`timescale 1ns/1ns
module cis_host_model (
	input wire logic sys_clk,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~v;
	endtask
	// Data stands only in the cycle after the strobe, so sample it there
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
endmodule

// file: cis_pkg.sv
// Package of constants and types for the charger input supervisor
package cis_pkg;
	localparam int CIS_MV_W = 14;
	localparam logic [13:0] CIS_OVP_MV_0 = 14'd6600;
	localparam logic [13:0] CIS_OVP_MV_1 = 14'd7000;
	localparam logic [13:0] CIS_OVP_MV_2 = 14'd7500;
	localparam logic [13:0] CIS_OVP_MV_3 = 14'd8000;
	localparam logic [13:0] CIS_OVP_RESUME_MV = 14'd6000;
	localparam logic [13:0] CIS_UVLO_MV = 14'd3500;
	localparam logic [13:0] CIS_UVLO_HYST_MV = 14'd500;
	localparam logic [13:0] CIS_SAG_MV = 14'd200;
	localparam logic [13:0] CIS_WALL_THR_MV = 14'd1200;
	// Current codes in mA, then the wall and precondition divisors
	localparam logic [11:0] CIS_ILIM_USB_LO = 12'd100;
	localparam logic [11:0] CIS_ILIM_USB_HI = 12'd450;
	localparam logic [11:0] CIS_ILIM_WALL = 12'd2000;
	localparam logic [11:0] CIS_ICHG_USB_LO = 12'd90;
	localparam logic [11:0] CIS_ICHG_USB_HI = 12'd450;
	localparam logic [11:0] CIS_IPRE_USB = 12'd45;
	localparam logic [11:0] CIS_WALL_DIV = 12'd5;
	localparam logic [11:0] CIS_PRE_DIV = 12'd10;
	// Register map, word offsets
	localparam logic [3:0] CIS_ADDR_CTRL = 4'h0;
	localparam logic [3:0] CIS_ADDR_STAT = 4'h1;
	localparam logic [3:0] CIS_ADDR_CURR = 4'h2;
	localparam logic [3:0] CIS_ADDR_ILIM = 4'h3;
	localparam int CIS_CTRL_OVP_LSB = 0;
	localparam int CIS_CTRL_FLAG_EN = 2;
	localparam int CIS_CTRL_CON_EN = 3;
	localparam int CIS_CTRL_DIS_EN = 4;
	localparam logic [7:0] CIS_CTRL_RESET = 8'h00;
	typedef struct packed {
		logic [11:0] ilim_ma;
		logic [11:0] ichg_ma;
		logic [11:0] ipre_ma;
	} cis_curr_t;
	typedef enum logic [2:0] {
		CIS_ST_OFF = 3'b001,
		CIS_ST_OK = 3'b010,
		CIS_ST_OVP = 3'b100
	} cis_state_t;
endpackage
